// file: rtl/pho_freq_mon.sv
`timescale 1ns/1ps
`default_nettype none
// flags a slow input when no edge arrives within i_limit cycles
module pho_freq_mon #(
  parameter int W = 16
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  input  wire logic         i_edge,
  input  wire logic [W-1:0] i_limit,
  output logic              o_below
);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_reg <= '0;
    end else if (i_edge) begin
      cnt_reg <= '0;
    end else if (cnt_reg < i_limit) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_below <= 1'b0;
    end else if (i_edge) begin
      o_below <= 1'b0;
    end else if (cnt_reg >= i_limit) begin
      o_below <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: rtl/pho_holdover.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pho_map.svh"
module pho_holdover
  import pho_pkg::*;
#(
  parameter int AW = 10,
  parameter int FW = 16,
  parameter logic [FW-1:0] REF_NORM = `PHO_FM_REF_NORM,
  parameter logic [FW-1:0] REF_EXT  = `PHO_FM_REF_EXT,
  parameter logic [FW-1:0] OSC_LIM  = `PHO_FM_OSC
) (
  input  wire logic          i_clk,
  input  wire logic          i_reset_n,
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [7:0]    i_wdata,
  input  wire logic          i_wr,
  input  wire logic          i_rd,
  output logic      [7:0]    o_rdata,
  input  wire logic          i_resync_n,
  input  wire logic          i_ref_one,
  input  wire logic          i_ref_two,
  input  wire logic          i_ref_sel_two,
  input  wire logic          i_vco,
  input  wire logic          i_clk_input,
  input  wire logic          i_lock_status_pin,
  input  wire logic          i_pd_in_lock_win,
  input  wire logic          i_pd_over_unlock,
  output logic               o_charge_pump_tristate,
  output logic               o_b_counter_reset,
  output logic               o_digital_lock_indicator,
  output logic               o_lock_pin_src,
  output logic               o_lock_pin_sink,
  output logic      [5:0]    o_lock_pin_mode,
  output logic               o_window_high_range,
  output logic               o_lock_detect_off,
  output logic               o_auto_switchover,
  output logic               o_prefer_ref_two,
  output logic      [1:0]    o_ref_buf_en,
  output logic      [3:0]    o_chan_outputs_off,
  output logic               o_ref_one_slow,
  output logic               o_ref_two_slow,
  output logic               o_osc_slow,
  output logic               o_pll_off,
  output logic               o_fb_from_clk_input,
  output logic               o_ext_zero_delay
);
  logic [7:0] ld_cfg_reg;
  logic [7:0] lp_cfg_reg;
  logic [7:0] rs_cfg_reg;
  logic [7:0] ho_cfg_reg;
  logic [7:0] div_cfg_reg [4];
  logic [1:0] route_reg;
  logic [8:0] s1_reg;
  logic [8:0] s2_reg;
  logic [8:0] s3_reg;
  logic [7:0] win_cnt_reg;
  logic       dld_reg;
  logic       tri_reg;
  logic       brst_reg;
  logic [3:0] off_reg;
  pho_state_t state_reg;
  pho_state_t state_next;
  pho_route_t route;
  logic       sync_s;
  logic       sync_fall;
  logic       reference_input_one_edge;
  logic       reference_input_two_edge;
  logic       ref_edge;
  logic       vco_edge;
  logic       cki_edge;
  logic       lock_s;
  logic       in_win_s;
  logic       over_s;
  logic       ho_en;
  logic       manual;
  logic       cmp_en;
  logic       lock_sensed;
  logic       enter;
  logic       release_ok;
  logic [7:0] win_target;

  function automatic logic [7:0] lock_count(input logic [1:0] code);
    unique case (code)
      2'b00:   lock_count = `PHO_LD_CNT_C0;
      2'b01:   lock_count = `PHO_LD_CNT_C1;
      2'b10:   lock_count = `PHO_LD_CNT_C2;
      2'b11:   lock_count = `PHO_LD_CNT_C3;
    endcase
  endfunction

  // register writes
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ld_cfg_reg <= `PHO_RST_CFG;
      lp_cfg_reg <= `PHO_RST_CFG;
      rs_cfg_reg <= `PHO_RST_CFG;
      ho_cfg_reg <= `PHO_RST_CFG;
      route_reg  <= 2'h0;
      for (int i = 0; i < 4; i++) begin
        div_cfg_reg[i] <= `PHO_RST_CFG;
      end
    end else if (i_wr) begin
      unique case (i_addr)
        `PHO_A_LOCK_DET: ld_cfg_reg <= i_wdata;
        `PHO_A_LOCK_PIN: lp_cfg_reg <= i_wdata;
        `PHO_A_REF_SEL:  rs_cfg_reg <= i_wdata;
        `PHO_A_HOLDOVER: ho_cfg_reg <= i_wdata;
        `PHO_A_DIV0:     div_cfg_reg[0] <= i_wdata;
        `PHO_A_DIV1:     div_cfg_reg[1] <= i_wdata;
        `PHO_A_DIV2:     div_cfg_reg[2] <= i_wdata;
        `PHO_A_DIV3:     div_cfg_reg[3] <= i_wdata;
        `PHO_A_ROUTE:    route_reg <= i_wdata[1:0];
        default: ;
      endcase
    end
  end

  // register reads, one cycle later
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        `PHO_A_LOCK_DET: o_rdata <= ld_cfg_reg;
        `PHO_A_LOCK_PIN: o_rdata <= lp_cfg_reg;
        `PHO_A_REF_SEL:  o_rdata <= rs_cfg_reg;
        `PHO_A_HOLDOVER: o_rdata <= ho_cfg_reg;
        `PHO_A_DIV0:     o_rdata <= div_cfg_reg[0];
        `PHO_A_DIV1:     o_rdata <= div_cfg_reg[1];
        `PHO_A_DIV2:     o_rdata <= div_cfg_reg[2];
        `PHO_A_DIV3:     o_rdata <= div_cfg_reg[3];
        `PHO_A_ROUTE:    o_rdata <= {6'h00, route_reg};
        `PHO_A_STATUS:   o_rdata <= {o_osc_slow, o_ref_two_slow,
                                     o_ref_one_slow, dld_reg,
                                     lock_sensed, tri_reg,
                                     state_reg == PHO_REARM,
                                     state_reg == PHO_HOLD};
        default:         o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_reg <= 9'h001;
      s2_reg <= 9'h001;
      s3_reg <= 9'h001;
    end else begin
      s1_reg <= {i_pd_over_unlock, i_pd_in_lock_win, i_lock_status_pin,
                 i_clk_input, i_vco, i_ref_sel_two, i_ref_two,
                 i_ref_one, i_resync_n};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign sync_s    = s2_reg[0];
  assign sync_fall = s3_reg[0] & ~s2_reg[0];
  assign reference_input_one_edge = s2_reg[1] & ~s3_reg[1];
  assign reference_input_two_edge = s2_reg[2] & ~s3_reg[2];
  assign vco_edge  = s2_reg[4] & ~s3_reg[4];
  assign cki_edge  = s2_reg[5] & ~s3_reg[5];
  assign lock_s    = s2_reg[6];
  assign in_win_s  = s2_reg[7];
  assign over_s    = s2_reg[8];
  assign ref_edge  = s2_reg[3] ? reference_input_two_edge : reference_input_one_edge;

  assign ho_en   = ho_cfg_reg[`PHO_B_HO_EN];
  assign manual  = ho_cfg_reg[`PHO_B_HO_EXT];
  assign cmp_en  = ho_cfg_reg[`PHO_B_HO_CMP];
  assign lock_sensed = cmp_en ? lock_s : 1'b1;

  assign enter = ho_en && state_reg == PHO_RUN &&
                 (manual ? sync_fall : !lock_sensed);
  assign release_ok = ref_edge && (!manual || sync_s);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PHO_RUN: begin
        if (enter) begin
          state_next = PHO_HOLD;
        end
      end
      PHO_HOLD: begin
        if (release_ok) begin
          state_next = manual ? PHO_RUN : PHO_REARM;
        end
      end
      PHO_REARM: begin
        // wait for sensed lock before re-arming
        if (lock_sensed) begin
          state_next = PHO_RUN;
        end
      end
      default: state_next = PHO_RUN;
    endcase
    if (!ho_en) begin
      state_next = PHO_RUN;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= PHO_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tri_reg  <= 1'b0;
      brst_reg <= 1'b0;
    end else begin
      tri_reg  <= state_next == PHO_HOLD;
      brst_reg <= ho_en && state_reg == PHO_HOLD && release_ok;
    end
  end

  assign o_charge_pump_tristate = tri_reg | enter;
  assign o_b_counter_reset      = brst_reg;

  assign win_target = lock_count(ld_cfg_reg[`PHO_B_LD_CNT_LO +: 2]);
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      win_cnt_reg <= 8'h00;
      dld_reg     <= 1'b0;
    end else if (ld_cfg_reg[`PHO_B_LD_DIS]) begin
      win_cnt_reg <= 8'h00;
      dld_reg     <= 1'b0;
    end else if (ref_edge) begin
      if (over_s) begin
        win_cnt_reg <= 8'h00;
        dld_reg     <= 1'b0;
      end else if (in_win_s) begin
        if (win_cnt_reg < win_target) begin
          win_cnt_reg <= win_cnt_reg + 8'h01;
        end
        if (win_cnt_reg + 8'h01 >= win_target) begin
          dld_reg <= 1'b1;
        end
      end else begin
        win_cnt_reg <= 8'h00;
      end
    end
  end
  assign o_digital_lock_indicator = dld_reg;
  assign o_lock_detect_off = ld_cfg_reg[`PHO_B_LD_DIS];
  assign o_window_high_range = ~ld_cfg_reg[`PHO_B_LD_WIN];

  assign o_lock_pin_mode = lp_cfg_reg[`PHO_B_LP_MODE_HI:0];
  assign o_lock_pin_src  = (o_lock_pin_mode == `PHO_LP_MODE_CS) & dld_reg;
  assign o_lock_pin_sink = (o_lock_pin_mode == `PHO_LP_MODE_CS) & ~dld_reg;

  assign o_auto_switchover = rs_cfg_reg[`PHO_B_RS_AUTO];
  assign o_prefer_ref_two  = rs_cfg_reg[`PHO_B_RS_PREF];
  assign o_ref_buf_en      = rs_cfg_reg[`PHO_B_RS_BUF_LO +: 2];

  // divider outputs off while pin low, except where the divider's ignore bit is set
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      off_reg <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        off_reg[i] <= !div_cfg_reg[i][`PHO_B_DIV_IGN] && !sync_s;
      end
    end
  end
  assign o_chan_outputs_off = off_reg;

  assign route               = pho_route_t'(route_reg);
  assign o_pll_off           = route == PHO_RT_DIST_ONLY;
  assign o_fb_from_clk_input = route == PHO_RT_EXT_VCO;
  assign o_ext_zero_delay    = route == PHO_RT_EXT_ZDM;

  logic [FW-1:0] ref_lim;
  assign ref_lim = lp_cfg_reg[`PHO_B_LP_MON_EXT] ? REF_EXT : REF_NORM;

  pho_freq_mon #(.W(FW)) u_mon_reference_input_one (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_edge    (reference_input_one_edge),
    .i_limit   (ref_lim),
    .o_below   (o_ref_one_slow)
  );
  pho_freq_mon #(.W(FW)) u_mon_reference_input_two (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_edge    (reference_input_two_edge),
    .i_limit   (ref_lim),
    .o_below   (o_ref_two_slow)
  );
  // oscillator monitor follows clock input when routed
  pho_freq_mon #(.W(FW)) u_mon_osc (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_edge    (route == PHO_RT_INT_VCO ? vco_edge : cki_edge),
    .i_limit   (OSC_LIM),
    .o_below   (o_osc_slow)
  );

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  property p_disabled_inert;
    !ho_en ##1 !ho_en |-> !o_charge_pump_tristate;
  endproperty
  a_disabled_inert: assert property (p_disabled_inert)
    else $error("holdover active while disabled");

  property p_manual_enter;
    ho_en && manual && sync_fall && state_reg == PHO_RUN
      |-> o_charge_pump_tristate ##1 tri_reg;
  endproperty
  a_manual_enter: assert property (p_manual_enter)
    else $error("falling resync did not tri-state pump");

  property p_release_on_ref;
    $fell(tri_reg) |-> $past(ref_edge) || $past(!ho_en);
  endproperty
  a_release_on_ref: assert property (p_release_on_ref)
    else $error("pump released without reference edge");

  property p_brst_with_release;
    $fell(tri_reg) && $past(ho_en) |-> o_b_counter_reset;
  endproperty
  a_brst_with_release: assert property (p_brst_with_release)
    else $error("b counter not reset at release");

  property p_chan_off;
    !div_cfg_reg[3][`PHO_B_DIV_IGN] && !sync_s ##1
      !div_cfg_reg[3][`PHO_B_DIV_IGN] |-> o_chan_outputs_off[3];
  endproperty
  a_chan_off: assert property (p_chan_off)
    else $error("divider output not turned off");

  property p_auto_enter;
    ho_en && !manual && !lock_sensed && state_reg == PHO_RUN
      |-> o_charge_pump_tristate;
  endproperty
  a_auto_enter: assert property (p_auto_enter)
    else $error("lock loss did not tri-state pump");

  property p_cmp_off;
    !cmp_en && !manual && state_reg == PHO_RUN |-> !o_charge_pump_tristate;
  endproperty
  a_cmp_off: assert property (p_cmp_off)
    else $error("holdover entered with comparator off");

  property p_rearm_block;
    state_reg == PHO_REARM |-> !o_charge_pump_tristate;
  endproperty
  a_rearm_block: assert property (p_rearm_block)
    else $error("holdover re-entered before lock");

  property p_lock_five;
    $rose(dld_reg) && $past(ld_cfg_reg[6:5]) == 2'b00
      |-> $past(win_cnt_reg) == 8'd4;
  endproperty
  a_lock_five: assert property (p_lock_five)
    else $error("lock set after wrong cycle count");

  property p_unlock_one;
    dld_reg && ref_edge && over_s |=> !dld_reg;
  endproperty
  a_unlock_one: assert property (p_unlock_one)
    else $error("lock not cleared on unlock cycle");

  c_manual: cover property (manual && enter ##[1:200] o_b_counter_reset);
  c_auto: cover property (!manual && enter ##[1:200] state_reg == PHO_REARM);
  c_lock: cover property ($rose(dld_reg));
  c_mon: cover property ($rose(o_ref_one_slow));
endmodule
`default_nettype wire

// file: rtl/pho_map.svh
`ifndef PHO_MAP_SVH
`define PHO_MAP_SVH

// register offsets
`define PHO_A_LOCK_DET    10'h018
`define PHO_A_LOCK_PIN    10'h01a
`define PHO_A_REF_SEL     10'h01c
`define PHO_A_HOLDOVER    10'h01d
`define PHO_A_DIV0        10'h191
`define PHO_A_DIV1        10'h194
`define PHO_A_DIV2        10'h197
`define PHO_A_DIV3        10'h19a
`define PHO_A_ROUTE       10'h0f0
`define PHO_A_STATUS      10'h0f1

// field positions
`define PHO_B_LD_CNT_LO   5
`define PHO_B_LD_WIN      4
`define PHO_B_LD_DIS      3
`define PHO_B_LP_MODE_HI  5
`define PHO_B_LP_MON_EXT  6
`define PHO_B_RS_AUTO     4
`define PHO_B_RS_PREF     3
`define PHO_B_RS_BUF_LO   1
`define PHO_B_HO_CMP      3
`define PHO_B_HO_EXT      1
`define PHO_B_HO_EN       0
`define PHO_B_DIV_IGN     6

// reset values
`define PHO_RST_CFG       8'h00

// encodings
`define PHO_LP_MODE_CS    6'h04

// lock detect cycle counts per counter code
`define PHO_LD_CNT_C0     8'd5
`define PHO_LD_CNT_C1     8'd16
`define PHO_LD_CNT_C2     8'd64
`define PHO_LD_CNT_C3     8'd255

// frequency monitor limits, in i_clk cycles between edges
`define PHO_FM_REF_NORM   16'd400
`define PHO_FM_REF_EXT    16'd4000
`define PHO_FM_OSC        16'd100

`endif

// file: rtl/pho_pkg.sv
`default_nettype none
package pho_pkg;
  typedef enum logic [1:0] {
    PHO_RUN,
    PHO_HOLD,
    PHO_REARM
  } pho_state_t;
  typedef enum logic [1:0] {
    PHO_RT_INT_VCO,
    PHO_RT_DIST_ONLY,
    PHO_RT_EXT_VCO,
    PHO_RT_EXT_ZDM
  } pho_route_t;
endpackage
`default_nettype wire

// file: testbench/pho_holdover_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pho_holdover_tb_top;
  logic       i_clk, i_reset_n, wr, rd, sel_two, lock_pin, win, unlock;
  logic       sync_low, ref_one, ref_two, resync_n, tri_st, b_rst, dli;
  logic       src, sink, whr, ldo, aso, pr2, s1, s2, so, poff, fb, zdm, prev;
  logic [9:0] addr;
  logic [7:0] wdata, rdata;
  logic [5:0] mode;
  logic [1:0] ref_on, buf_en;
  logic [3:0] off;
  int         fail_count, n_checks, i, e;

  pho_ref_model i_pho_ref_model (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_ref_on(ref_on), .i_sync_low(sync_low), .o_ref_one(ref_one),
    .o_ref_two(ref_two), .o_resync_n(resync_n));

  pho_holdover #(.REF_NORM(16'h0014), .REF_EXT(16'h0028),
    .OSC_LIM(16'h000a)) i_pho_holdover (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_resync_n(resync_n), .i_ref_one(ref_one),
    .i_ref_two(ref_two), .i_ref_sel_two(sel_two), .i_vco(ref_one),
    .i_clk_input(ref_two), .i_lock_status_pin(lock_pin),
    .i_pd_in_lock_win(win), .i_pd_over_unlock(unlock),
    .o_charge_pump_tristate(tri_st), .o_b_counter_reset(b_rst),
    .o_digital_lock_indicator(dli), .o_lock_pin_src(src),
    .o_lock_pin_sink(sink), .o_lock_pin_mode(mode),
    .o_window_high_range(whr), .o_lock_detect_off(ldo),
    .o_auto_switchover(aso), .o_prefer_ref_two(pr2), .o_ref_buf_en(buf_en),
    .o_chan_outputs_off(off), .o_ref_one_slow(s1), .o_ref_two_slow(s2),
    .o_osc_slow(so), .o_pll_off(poff), .o_fb_from_clk_input(fb),
    .o_ext_zero_delay(zdm));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic chk(input string nm, input logic [7:0] ex,
                     input logic [7:0] got);
    n_checks++;
    if (got !== ex) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic wreg(input logic [9:0] a, input logic [7:0] d);
    @(posedge i_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge i_clk);
    wr    <= 1'b0;
    #1;
  endtask

  task automatic rreg(input logic [9:0] a, input logic [7:0] ex);
    @(posedge i_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge i_clk);
    rd   <= 1'b0;
    #1 chk("rdata", ex, rdata);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // wait for release pulse, pump must leave high-Z with it
  task automatic wait_rel();
    for (i = 0; i < 40; i++) begin
      @(posedge i_clk);
      #1;
      if (b_rst === 1'b1) break;
    end
    chk("b_reset", 8'h1, 8'(b_rst));
    chk("tri_rel", 8'h0, 8'(tri_st));
    cyc(1);
    chk("b_pulse", 8'h0, 8'(b_rst));
  endtask

  task automatic at_ref_fall();
    while (ref_one !== 1'b1) @(posedge i_clk);
    while (ref_one === 1'b1) @(posedge i_clk);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #(20000 * 25);
    fail_count++;
    end_sim();
  end

  initial begin
    {i_reset_n, wr, rd, sel_two, lock_pin, win, unlock, sync_low} = '0;
    {addr, wdata, ref_on} = '0;
    repeat (10) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rreg(10'h018, 8'h00);
    rreg(10'h01a, 8'h00);
    rreg(10'h01c, 8'h00);
    rreg(10'h01d, 8'h00);
    rreg(10'h191, 8'h00);
    wreg(10'h3ff, 8'hff);
    rreg(10'h3ff, 8'h00);
    wreg(10'h01a, 8'h04);
    rreg(10'h01a, 8'h04);
    chk("lp_mode", 8'h04, 8'(mode));
    chk("lp_sink", 8'h1, 8'(sink));
    wreg(10'h01c, 8'h16);
    chk("refsel", 8'h0b, 8'({aso, pr2, buf_en}));
    wreg(10'h018, 8'h08);
    chk("ld_off", 8'h1, 8'(ldo));
    wreg(10'h018, 8'h00);
    chk("win_hi", 8'h2, 8'({whr, ldo}));
    for (e = 1; e < 4; e++) begin
      wreg(10'h0f0, 8'(e));
      chk("route", 8'({e == 1, e == 3}), 8'({poff, zdm}));
      if (e == 2) chk("fb", 8'h1, 8'(fb));
    end
    wreg(10'h0f0, 8'h00);
    wreg(10'h191, 8'h40);
    wreg(10'h01d, 8'h02);
    sync_low <= 1'b1;
    cyc(6);
    chk("tri_off", 8'h0, 8'(tri_st));
    chk("ch_off", 8'h0e, 8'(off));
    sync_low <= 1'b0;
    wreg(10'h01d, 8'h03);
    cyc(6);
    sync_low <= 1'b1;
    cyc(5);
    chk("tri_man", 8'h1, 8'(tri_st));
    rreg(10'h0f1, 8'hed);
    sync_low <= 1'b0;
    cyc(20);
    chk("tri_noref", 8'h1, 8'(tri_st));
    sel_two <= 1'b1;
    ref_on  <= 2'b01;
    cyc(24);
    chk("tri_other", 8'h1, 8'(tri_st));
    sel_two <= 1'b0;
    wait_rel();
    ref_on   <= 2'b00;
    lock_pin <= 1'b1;
    wreg(10'h01d, 8'h09);
    cyc(5);
    lock_pin <= 1'b0;
    cyc(5);
    chk("tri_auto", 8'h1, 8'(tri_st));
    cyc(30);
    chk("tri_hold", 8'h1, 8'(tri_st));
    ref_on <= 2'b01;
    wait_rel();
    ref_on <= 2'b00;
    cyc(16);
    chk("tri_rearm", 8'h0, 8'(tri_st));
    lock_pin <= 1'b1;
    cyc(5);
    lock_pin <= 1'b0;
    cyc(5);
    chk("tri_again", 8'h1, 8'(tri_st));
    wreg(10'h01d, 8'h08);
    cyc(3);
    chk("tri_dis", 8'h0, 8'(tri_st));
    wreg(10'h01d, 8'h01);
    cyc(30);
    chk("tri_nocmp", 8'h0, 8'(tri_st));
    // lock indicator, five edges for code 00
    ref_on <= 2'b01;
    at_ref_fall();
    win  <= 1'b1;
    prev = 1'b0;
    e    = 0;
    for (i = 0; i < 80 && dli !== 1'b1; i++) begin
      @(posedge i_clk);
      if (ref_one === 1'b1 && prev === 1'b0) e++;
      prev = ref_one;
    end
    chk("ld_edges", 8'h05, 8'(e));
    chk("lp_src", 8'h1, 8'(src));
    at_ref_fall();
    win    <= 1'b0;
    unlock <= 1'b1;
    cyc(12);
    chk("dli_drop", 8'h0, 8'(dli));
    unlock <= 1'b0;
    ref_on <= 2'b01;
    cyc(30);
    chk("slow_run", 8'h2, 8'({s1, s2, so}));
    wreg(10'h01a, 8'h44);
    ref_on <= 2'b00;
    cyc(30);
    chk("slow_ext", 8'h0, 8'(s1));
    chk("osc_slow", 8'h1, 8'(so));
    cyc(20);
    chk("slow_ext2", 8'h1, 8'(s1));
    wreg(10'h01a, 8'h04);
    ref_on <= 2'b01;
    cyc(20);
    ref_on <= 2'b00;
    cyc(30);
    chk("slow_norm", 8'h1, 8'(s1));
    end_sim();
  end
endmodule
`default_nettype wire

// file: testbench/pho_ref_model.sv
`timescale 1ns/1ps
`default_nettype none
// reference clock source and resync pin driver
module pho_ref_model #(
  parameter int HALF = 4
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic [1:0] i_ref_on,
  input  wire logic       i_sync_low,
  output logic            o_ref_one,
  output logic            o_ref_two,
  output logic            o_resync_n
);
  logic [7:0] cnt_reg;
  logic       phase;
  assign phase = cnt_reg < 8'(HALF);
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_reg    <= 8'h00;
      o_ref_one  <= 1'b0;
      o_ref_two  <= 1'b0;
      o_resync_n <= 1'b1;
    end else begin
      cnt_reg    <= (cnt_reg == 8'(2*HALF-1)) ? 8'h00 : cnt_reg + 8'h01;
      o_ref_one  <= i_ref_on[0] & phase;
      o_ref_two  <= i_ref_on[1] & phase;
      o_resync_n <= !i_sync_low;
    end
  end
endmodule
`default_nettype wire
